//--- verilog/sacc_consts.svh
/*
  timing counts and code constants of the converter control pair.
  assumes a 20 MHz clock; included by its bare name.
*/
`ifndef SACC_CONSTS_SVH
`define SACC_CONSTS_SVH
`define SACC_CLK_NS 50
`define SACC_ACQ_NS 400
`define SACC_ACQ_CYC ((`SACC_ACQ_NS + `SACC_CLK_NS - 1) / `SACC_CLK_NS)
`define SACC_CONV_NS 1500
`define SACC_CONV_CYC (`SACC_CONV_NS / `SACC_CLK_NS)
`define SACC_LATCH_CYC 1
`define SACC_MIDSCALE 16'h8000
`define SACC_REG_CTRL 2'h0
`define SACC_REG_STAT 2'h1
`define SACC_REG_MASK 2'h2
`define SACC_REG_DATA 2'h3
`define SACC_CTRL_START 0
`define SACC_CTRL_SLEEP 1
`define SACC_CTRL_REFOFF 2
`define SACC_CTRL_BUFOFF 3
`define SACC_CTRL_CODE 4
`define SACC_CTRL_RESET 5
`define SACC_EV_READY 0
`define SACC_EV_ABORT 1
`endif

//--- verilog/sacc_pkg.sv
/*
  types shared by the converter control pair.
  assumes nothing beyond the constants header.
*/
package sacc_pkg;
  typedef logic [15:0] sacc_word_t;
  typedef enum logic [4:0] {
    SACC_ACQ = 5'b00001,
    SACC_WAIT_HI = 5'b00010,
    SACC_WAIT_FALL = 5'b00100,
    SACC_CONV = 5'b01000,
    SACC_SLEEP = 5'b10000
  } sacc_state_t;
endpackage

//--- verilog/sacc_if.sv
/*
  pin bundle between converter control and its host.
  assumes both ends share i_clk; the data bus drive is one active-low enable, data_oe_n.
*/
`timescale 1ns/10ps
interface sacc_if;
  logic conversion_start_n;
  logic busy;
  logic reset;
  logic sleep_request;
  logic internal_ref_off;
  logic ref_buffer_off;
  logic output_code_select;
  logic cs_n;
  logic rd_n;
  logic sclk;
  logic [15:0] data;
  logic data_oe_n;
  modport device (
    input conversion_start_n, reset, sleep_request, internal_ref_off,
    input ref_buffer_off, output_code_select, cs_n, rd_n, sclk,
    output busy, data, data_oe_n
  );
  modport host (
    output conversion_start_n, reset, sleep_request, internal_ref_off,
    output ref_buffer_off, output_code_select, cs_n, rd_n, sclk,
    input busy, data, data_oe_n
  );
endinterface

//--- verilog/sacc_device.sv
/*
  converter control end: acquisition timing, start modes, busy, read gating.
  assumes pins arrive asynchronously and pass two flip-flops here; the
  successive-approximation result comes from i_sample.
*/
// Local design decisions: the strobed register port and the register addresses.
// Overview of operation
// - busy high from start until result latched
// - host takes busy fall as ready
// - drivers enabled only with select and read low
// - serial clock ignored while select high
// - reset aborts conversion, no result
// - sleep finishes current conversion, then blocks
// - start high at acquire end: convert on fall
// - start low at acquire end: convert at once
// - reference off low keeps reference on
// - reference off high powers reference down
// - buffer off select switches reference buffer
// - result straight binary or twos complement
`timescale 1ns/10ps
`include "sacc_consts.svh"
module sacc_device (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // analog result
  input wire sacc_pkg::sacc_word_t i_sample,
  // pins
  sacc_if.device pins,
  // analog controls and status
  output logic o_ref_enable,
  output logic o_buf_enable,
  output logic o_hold,
  output logic o_sleeping,
  output logic [15:0] o_sclk_count
);
  import sacc_pkg::*;
  //////////////////////////////////////////////////////////////////////
  // two-flop synchronisers
  localparam int NS = 9;
  logic [NS-1:0] raw;
  logic [NS-1:0] s1_q;
  logic [NS-1:0] s2_q;
  assign raw = {pins.conversion_start_n, pins.reset, pins.sleep_request,
                pins.internal_ref_off, pins.ref_buffer_off,
                pins.output_code_select, pins.cs_n, pins.rd_n, pins.sclk};
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_q <= 9'h106;
      s2_q <= 9'h106;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end
  logic cnv_n;
  logic rst_pin;
  logic sleep_req;
  logic ref_off;
  logic buf_off;
  logic code_sb;
  logic cs_n;
  logic rd_n;
  logic sclk;
  assign {cnv_n, rst_pin, sleep_req, ref_off, buf_off, code_sb, cs_n, rd_n, sclk} = s2_q;
  //////////////////////////////////////////////////////////////////////
  // conversion sequencer
  sacc_state_t st_q, st_d;
  logic [7:0] cnt_q, cnt_d;
  logic cnv_prev_q, cnv_prev_d;
  sacc_word_t res_q, res_d;
  logic busy_q, busy_d;
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    res_d = res_q;
    busy_d = busy_q;
    cnv_prev_d = cnv_n;
    if (rst_pin) begin
      st_d = SACC_ACQ;
      cnt_d = 8'h00;
      busy_d = 1'b0;
    end else begin
      unique case (st_q)
        SACC_ACQ: begin
          if (cnt_q >= 8'(`SACC_ACQ_CYC - 1)) begin
            cnt_d = 8'h00;
            if (sleep_req) begin
              st_d = SACC_SLEEP;
            end else if (cnv_n) begin
              st_d = SACC_WAIT_FALL;
            end else begin
              st_d = SACC_CONV;
              busy_d = 1'b1;
            end
          end else begin
            cnt_d = cnt_q + 8'h01;
          end
        end
        SACC_WAIT_HI: begin
          st_d = SACC_WAIT_FALL;
        end
        SACC_WAIT_FALL: begin
          if (sleep_req) begin
            st_d = SACC_SLEEP;
          end else if (cnv_prev_q && !cnv_n) begin
            st_d = SACC_CONV;
            busy_d = 1'b1;
          end
        end
        SACC_CONV: begin
          if (cnt_q >= 8'(`SACC_CONV_CYC + `SACC_LATCH_CYC - 1)) begin
            cnt_d = 8'h00;
            res_d = code_sb ? i_sample : (i_sample ^ `SACC_MIDSCALE);
            busy_d = 1'b0;
            st_d = SACC_ACQ;
          end else begin
            cnt_d = cnt_q + 8'h01;
          end
        end
        SACC_SLEEP: begin
          if (!sleep_req) begin
            st_d = SACC_ACQ;
            cnt_d = 8'h00;
          end
        end
        default: begin
          st_d = SACC_ACQ;
        end
      endcase
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= SACC_ACQ;
      cnt_q <= 8'h00;
      res_q <= 16'h0000;
      busy_q <= 1'b0;
      cnv_prev_q <= 1'b1;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      res_q <= res_d;
      busy_q <= busy_d;
      cnv_prev_q <= cnv_prev_d;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // read gating and gated serial clock edge count
  logic oe_n_q, oe_n_d;
  logic sclk_prev_q, sclk_prev_d;
  logic [15:0] sck_q, sck_d;
  always_comb begin
    oe_n_d = !(!cs_n && !rd_n);
    sclk_prev_d = sclk;
    sck_d = sck_q;
    if (cs_n) begin
      sck_d = 16'h0000;
    end else if (sclk && !sclk_prev_q) begin
      sck_d = sck_q + 16'h0001;
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      oe_n_q <= 1'b1;
      sclk_prev_q <= 1'b0;
      sck_q <= 16'h0000;
    end else begin
      oe_n_q <= oe_n_d;
      sclk_prev_q <= sclk_prev_d;
      sck_q <= sck_d;
    end
  end
  assign pins.busy = busy_q;
  assign pins.data = res_q;
  assign pins.data_oe_n = oe_n_q;
  assign o_ref_enable = !ref_off;
  assign o_buf_enable = !buf_off;
  assign o_hold = (st_q == SACC_CONV);
  assign o_sleeping = (st_q == SACC_SLEEP);
  assign o_sclk_count = sck_q;
endmodule

//--- verilog/sacc_host.sv
/*
  host end: register port for software, drives the control pins, catches
  busy falls as ready events and reads each result.
  assumes the device end shares i_clk; device outputs are resynchronised.
*/
`timescale 1ns/10ps
`include "sacc_consts.svh"
module sacc_host (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // register port
  input wire logic [1:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  output logic o_irq,
  // pins
  sacc_if.host pins
);
  import sacc_pkg::*;
  //////////////////////////////////////////////////////////////////////
  // control register and start pulse
  logic [5:0] ctrl_q, ctrl_d;
  logic [1:0] stat_q, stat_d;
  logic [1:0] mask_q, mask_d;
  logic [15:0] data_q, data_d;
  logic [15:0] rdata_q, rdata_d;
  logic [2:0] rs_q, rs_d;
  logic abort_pend_q, abort_pend_d;
  logic bsy_prev_q, bsy_prev_d;
  logic [17:0] sync_d;
  logic [17:0] sync1_q;
  logic [17:0] sync2_q;
  assign sync_d = {pins.busy, pins.data_oe_n, pins.data};
  always_comb begin
    ctrl_d = ctrl_q;
    ctrl_d[`SACC_CTRL_START] = 1'b0;
    ctrl_d[`SACC_CTRL_RESET] = 1'b0;
    mask_d = mask_q;
    stat_d = stat_q;
    data_d = data_q;
    rdata_d = 16'h0000;
    rs_d = rs_q;
    abort_pend_d = abort_pend_q;
    bsy_prev_d = sync2_q[17];
    if (i_rd) begin
      unique case (i_addr)
        `SACC_REG_CTRL: rdata_d = {10'h000, ctrl_q};
        `SACC_REG_STAT: rdata_d = {13'h0000, sync2_q[17], stat_q};
        `SACC_REG_MASK: rdata_d = {14'h0000, mask_q};
        default: rdata_d = data_q;
      endcase
      if (i_addr == `SACC_REG_STAT) begin
        stat_d = 2'b00;
      end
    end
    if (i_wr && i_addr == `SACC_REG_CTRL) begin
      ctrl_d = i_wdata[5:0];
    end
    if (i_wr && i_addr == `SACC_REG_MASK) begin
      mask_d = i_wdata[1:0];
    end
    if (ctrl_q[`SACC_CTRL_RESET]) begin
      stat_d[`SACC_EV_ABORT] = 1'b1;
    end
    // busy fall starts a read of the new result
    // a busy fall caused by our own abort carries no result
    if (bsy_prev_q && !sync2_q[17] && rs_q == 3'h0) begin
      abort_pend_d = 1'b0;
      if (!abort_pend_q) begin
        rs_d = 3'h1;
      end
    end else if (rs_q == 3'h5) begin
      data_d = sync2_q[15:0];
      stat_d[`SACC_EV_READY] = 1'b1;
      rs_d = 3'h0;
    end else if (rs_q != 3'h0) begin
      rs_d = rs_q + 3'h1;
    end
    if (ctrl_q[`SACC_CTRL_RESET]) begin
      abort_pend_d = 1'b1;
    end else if (ctrl_q[`SACC_CTRL_START]) begin
      abort_pend_d = 1'b0;
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_q <= 6'h00;
      stat_q <= 2'b00;
      mask_q <= 2'b00;
      data_q <= 16'h0000;
      rdata_q <= 16'h0000;
      rs_q <= 3'h0;
      abort_pend_q <= 1'b0;
      bsy_prev_q <= 1'b0;
      sync1_q <= 18'h0_0000;
      sync2_q <= 18'h0_0000;
    end else begin
      ctrl_q <= ctrl_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      data_q <= data_d;
      rdata_q <= rdata_d;
      rs_q <= rs_d;
      abort_pend_q <= abort_pend_d;
      bsy_prev_q <= bsy_prev_d;
      sync1_q <= sync_d;
      sync2_q <= sync1_q;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // pins: start held low one cycle per request, else high
  assign pins.conversion_start_n = !ctrl_q[`SACC_CTRL_START];
  assign pins.reset = ctrl_q[`SACC_CTRL_RESET];
  assign pins.sleep_request = ctrl_q[`SACC_CTRL_SLEEP];
  assign pins.internal_ref_off = ctrl_q[`SACC_CTRL_REFOFF];
  assign pins.ref_buffer_off = ctrl_q[`SACC_CTRL_BUFOFF];
  assign pins.output_code_select = ctrl_q[`SACC_CTRL_CODE];
  assign pins.cs_n = (rs_q == 3'h0);
  assign pins.rd_n = (rs_q == 3'h0);
  assign pins.sclk = 1'b0;
  assign o_rdata = rdata_q;
  assign o_irq = |(stat_q & mask_q);
endmodule

//--- verification/sacc_checker.sv
/*
  pin assertions for the converter control pair.
  assumes the bench ties each pin input to the interface signal of that name.
*/
`timescale 1ns/10ps
`include "sacc_consts.svh"
module sacc_checker (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // pins
  input wire logic conversion_start_n,
  input wire logic busy,
  input wire logic reset,
  input wire logic sleep_request,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic [15:0] data,
  input wire logic data_oe_n
);
  logic [7:0] len_q, len_d, slp_q, slp_d;
  logic abt_q, abt_d;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////////////////////////////////////////
  // busy length, abort seen during busy, cycles of sleep request
  always_comb begin
    len_d = busy ? len_q + 8'h01 : 8'h00;
    abt_d = busy & (abt_q | reset);
    slp_d = !sleep_request ? 8'h00 : slp_q + {7'h00, slp_q != 8'hff};
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      len_q <= 8'h00;
      abt_q <= 1'b0;
      slp_q <= 8'h00;
    end else begin
      len_q <= len_d;
      abt_q <= abt_d;
      slp_q <= slp_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_busy_length: assert property (
    $fell(busy) && !abt_q |-> int'(len_q) == `SACC_CONV_CYC + `SACC_LATCH_CYC)
    else $error("busy length differs from conversion plus latch");
  a_busy_cause: assert property (
    $rose(busy) |-> $past(!conversion_start_n, 3) || $past(!conversion_start_n, 4))
    else $error("busy rose without a start request");
  a_reset_abort: assert property (
    reset && busy |-> ##[1:5] !busy)
    else $error("reset did not end the conversion");
  a_data_at_fall: assert property (
    !$stable(data) |-> !busy && ($past(busy) || $past(busy, 2)))
    else $error("result changed away from busy fall");
  a_sleep_block: assert property (
    $rose(busy) |-> slp_q < 8'h30)
    else $error("conversion started during sleep");
  a_oe_cause: assert property (
    !data_oe_n |-> $past(!cs_n && !rd_n, 3) || $past(!cs_n && !rd_n, 4))
    else $error("output enabled without select and read");
  a_cs_gate: assert property (
    cs_n [*5] |-> data_oe_n)
    else $error("output enabled while deselected");
  a_rd_gate: assert property (
    rd_n [*5] |-> data_oe_n)
    else $error("output enabled without read strobe");
endmodule

//--- verification/sacc_tb_top.sv
/*
  self-checking bench: host and device joined by the pin interface.
  assumes the register map and timing of the design constants header.
*/
`timescale 1ns/10ps
`include "sacc_consts.svh"
module sar_adc_conversion_control_tb_top;
  import sacc_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata, sclk_cnt, v, ctl;
  logic irq, ref_en, buf_en, sleeping;
  sacc_word_t sample = 16'h0000;
  int err_total = 0;
  int checked = 0;
  int cycles = 0;
  logic [15:0] exp_q[$];
  sacc_if bus();
  sacc_device u_sacc_device (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_sample(sample),
    .pins(bus), .o_ref_enable(ref_en), .o_buf_enable(buf_en), .o_hold(),
    .o_sleeping(sleeping), .o_sclk_count(sclk_cnt));
  sacc_host u_sacc_host (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq), .pins(bus));
  sacc_checker u_sacc_checker (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .conversion_start_n(bus.conversion_start_n), .busy(bus.busy), .reset(bus.reset),
    .sleep_request(bus.sleep_request), .cs_n(bus.cs_n), .rd_n(bus.rd_n),
    .data(bus.data), .data_oe_n(bus.data_oe_n));
  always #25 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 8000) begin
      err_total++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [1:0] a, input logic [15:0] d);
    @(posedge i_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [1:0] a);
    @(posedge i_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic wait_irq(output bit got);
    got = 1'b0;
    for (int i = 0; i < 80 && !got; i++) begin
      @(posedge i_clk);
      got = (irq === 1'b1);
    end
  endtask
  // start, write ctl|mid part way through, then read result and status
  task automatic conv(input bit code, input logic [15:0] mid);
    logic [15:0] s;
    bit got;
    s = 16'($urandom);
    repeat (12) @(posedge i_clk);
    sample <= s;
    ctl[4] = code;
    wr_reg(`SACC_REG_CTRL, ctl | 16'h0001);
    repeat (8) @(posedge i_clk);
    wr_reg(`SACC_REG_CTRL, ctl | mid);
    if (!mid[5]) exp_q.push_back(code ? s : s ^ 16'h8000);
    wait_irq(got);
    chk(16'(got), 16'(!mid[5]));
    rd_reg(`SACC_REG_DATA);
    chk(v, exp_q[$]);
    rd_reg(`SACC_REG_STAT);
    chk(v & 16'h0003, mid[5] ? 16'h0002 : 16'h0001);
    @(posedge i_clk);
    #1 chk(16'(irq), 16'h0000);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    bit got;
    void'($urandom(3));
    ctl = 16'h0000;
    exp_q.push_back(16'h0000);
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd_reg(`SACC_REG_STAT);
    chk(v, 16'h0000);
    wr_reg(`SACC_REG_MASK, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      ctl = 16'(i << 2);
      wr_reg(`SACC_REG_CTRL, ctl);
      repeat (4) @(posedge i_clk);
      chk({ref_en, buf_en}, {~ctl[2], ~ctl[3]});
      conv(i[0], 16'h0000);
    end
    chk(sclk_cnt, 16'h0000);
    conv(1'b1, 16'h0020);
    conv(1'b0, 16'h0000);
    conv(1'b1, 16'h0002);
    ctl[1] = 1'b1;
    repeat (12) @(posedge i_clk);
    wr_reg(`SACC_REG_CTRL, ctl | 16'h0001);
    wait_irq(got);
    chk(16'(got), 16'h0000);
    chk(16'(sleeping), 16'h0001);
    ctl[1] = 1'b0;
    wr_reg(`SACC_REG_CTRL, ctl);
    conv(1'b0, 16'h0000);
    wrap_up();
  end
endmodule
